// *** hw/efd_pkg.sv ***
package efd_pkg;
    // register byte offsets on the AXI4-Lite port
    localparam logic [7:0] EFD_OFF_CTRL = 8'h00;
    localparam logic [7:0] EFD_OFF_STAT = 8'h04;
    localparam logic [7:0] EFD_OFF_PKT = 8'h08;
    localparam logic [7:0] EFD_OFF_WARN = 8'h0c;
    // control register fields
    localparam int EFD_CTRL_EN_BIT = 0;
    localparam int EFD_CTRL_SRC_LSB = 1;
    localparam int EFD_CTRL_TIMING_BIT = 4;
    localparam int EFD_CTRL_AUTO_BIT = 5;
    localparam int EFD_CTRL_WARN_EN_BIT = 6;
    // status register fields
    localparam int EFD_STAT_REQ_BIT = 0;
    localparam int EFD_STAT_BUSY_BIT = 1;
    localparam int EFD_STAT_AUTO_BIT = 2;
    localparam int EFD_STAT_DONE_BIT = 3;
    localparam int EFD_STAT_MODE_OK_BIT = 4;
    localparam int EFD_STAT_MUX_BIT = 5;
    localparam int EFD_STAT_CNT_LSB = 8;
    localparam int EFD_STAT_PKT_LSB = 16;
    // reset values
    localparam logic [6:0] EFD_CTRL_RST = 7'h00;
    localparam logic [6:0] EFD_WARN_RST = 7'h20;
    localparam logic [8:0] EFD_PKT_RST = 9'h000;
    // pin synchroniser reset: strobes, acknowledge and selects idle high
    localparam logic [13:0] EFD_SYNC_RST = 14'h3f00;
    // endpoint and packet geometry
    localparam logic [6:0] EFD_FIFO_DEPTH = 7'h40;
    localparam logic [8:0] EFD_MAX_PKTS = 9'h100;
    localparam logic [2:0] EFD_EP_FIRST = 3'h1;
    localparam logic [2:0] EFD_EP_LAST = 3'h6;
    localparam logic [1:0] EFD_RESP_OKAY = 2'h0;
    localparam logic [1:0] EFD_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EFD_IDLE = 2'b00,
        EFD_REQ = 2'b01,
        EFD_XFER = 2'b11,
        EFD_DONE = 2'b10
    } efd_state_e;
endpackage

// *** hw/efd_regs_if.sv ***
`timescale 1ns/1ps
interface efd_regs_if;
    logic dma_en;
    logic [2:0] src_ep;
    logic timing_sel;
    logic auto_mode;
    logic warn_en;
    logic [6:0] warn_lvl;
    logic pkt_load;
    logic [8:0] pkt_value;
    logic req;
    logic busy;
    logic auto_active;
    logic mode_ok;
    logic multiplexed;
    logic done_set;
    logic [6:0] byte_cnt;
    logic [8:0] pkt_left;

    modport regs (
        output dma_en, src_ep, timing_sel, auto_mode, warn_en, warn_lvl, pkt_load, pkt_value,
        input req, busy, auto_active, mode_ok, multiplexed, done_set, byte_cnt, pkt_left
    );
    modport core (
        input dma_en, src_ep, timing_sel, auto_mode, warn_en, warn_lvl, pkt_load, pkt_value,
        output req, busy, auto_active, mode_ok, multiplexed, done_set, byte_cnt, pkt_left
    );
endinterface

// *** hw/efd_axil_regs.sv ***
`timescale 1ns/1ps
module efd_axil_regs
    import efd_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // core side
    efd_regs_if.regs rif
);
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [6:0] ctrl, next_ctrl;
    logic [6:0] warn, next_warn;
    logic [8:0] pkt, next_pkt;
    logic pkt_load, next_pkt_load;
    logic done_flag, next_done_flag;
    logic [31:0] stat_word;
    logic have_aw, have_w;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    assign s_axil_awready = !aw_held && !bvalid;
    assign s_axil_wready = !w_held && !bvalid;
    assign s_axil_arready = !rvalid;
    assign s_axil_bvalid = bvalid;
    assign s_axil_bresp = bresp;
    assign s_axil_rvalid = rvalid;
    assign s_axil_rdata = rdata;
    assign s_axil_rresp = rresp;
    assign rif.dma_en = ctrl[EFD_CTRL_EN_BIT];
    assign rif.src_ep = ctrl[EFD_CTRL_SRC_LSB +: 3];
    assign rif.timing_sel = ctrl[EFD_CTRL_TIMING_BIT];
    assign rif.auto_mode = ctrl[EFD_CTRL_AUTO_BIT];
    assign rif.warn_en = ctrl[EFD_CTRL_WARN_EN_BIT];
    assign rif.warn_lvl = warn;
    assign rif.pkt_load = pkt_load;
    assign rif.pkt_value = pkt;

    always_comb
    begin
        stat_word = 32'h0;
        stat_word[EFD_STAT_REQ_BIT] = rif.req;
        stat_word[EFD_STAT_BUSY_BIT] = rif.busy;
        stat_word[EFD_STAT_AUTO_BIT] = rif.auto_active;
        stat_word[EFD_STAT_DONE_BIT] = done_flag;
        stat_word[EFD_STAT_MODE_OK_BIT] = rif.mode_ok;
        stat_word[EFD_STAT_MUX_BIT] = rif.multiplexed;
        stat_word[EFD_STAT_CNT_LSB +: 7] = rif.byte_cnt;
        stat_word[EFD_STAT_PKT_LSB +: 9] = rif.pkt_left;
    end

    always_comb
    begin
        have_aw = aw_held || (s_axil_awvalid && s_axil_awready);
        have_w = w_held || (s_axil_wvalid && s_axil_wready);
        wa = aw_held ? aw_addr : s_axil_awaddr;
        wd = w_held ? w_data : s_axil_wdata;
        ws = w_held ? w_strb : s_axil_wstrb;
        next_aw_held = have_aw;
        next_w_held = have_w;
        next_aw_addr = wa;
        next_w_data = wd;
        next_w_strb = ws;
        next_bvalid = bvalid && !s_axil_bready;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_warn = warn;
        next_pkt = pkt;
        next_pkt_load = 1'b0;
        // the core's completion event wins over a same-cycle clear
        next_done_flag = done_flag;
        if (have_aw && have_w && !bvalid)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = EFD_RESP_OKAY;
            if (wa == EFD_OFF_CTRL)
            begin
                if (ws[0])
                    next_ctrl = wd[6:0];
            end
            else if (wa == EFD_OFF_STAT)
            begin
                if (ws[0] && wd[EFD_STAT_DONE_BIT])
                    next_done_flag = 1'b0;
            end
            else if (wa == EFD_OFF_PKT)
            begin
                if (ws[0])
                    next_pkt[7:0] = wd[7:0];
                if (ws[1])
                    next_pkt[8] = wd[8];
                next_pkt_load = |ws[1:0];
            end
            else if (wa == EFD_OFF_WARN)
            begin
                if (ws[0])
                    next_warn = wd[6:0];
            end
            else
                next_bresp = EFD_RESP_SLVERR;
        end
        if (rif.done_set)
            next_done_flag = 1'b1;
        next_rvalid = rvalid && !s_axil_rready;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axil_arvalid && s_axil_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = EFD_RESP_OKAY;
            next_rdata = 32'h0;
            if (s_axil_araddr == EFD_OFF_CTRL)
                next_rdata[6:0] = ctrl;
            else if (s_axil_araddr == EFD_OFF_STAT)
                next_rdata = stat_word;
            else if (s_axil_araddr == EFD_OFF_PKT)
                next_rdata[8:0] = pkt;
            else if (s_axil_araddr == EFD_OFF_WARN)
                next_rdata[6:0] = warn;
            else
                next_rresp = EFD_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= EFD_RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= EFD_RESP_OKAY;
            ctrl <= EFD_CTRL_RST;
            warn <= EFD_WARN_RST;
            pkt <= EFD_PKT_RST;
            pkt_load <= 1'b0;
            done_flag <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ctrl <= next_ctrl;
            warn <= next_warn;
            pkt <= next_pkt;
            pkt_load <= next_pkt_load;
            done_flag <= next_done_flag;
        end
    end
endmodule

// *** hw/efd_dma_core.sv ***
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - byte DMA only for endpoints one to six
// - no DMA while serial interface is selected
// - FIFO address internal, address pin ignored
// - chip select active overrides the acknowledge
// - request on threshold, packet end or immediately
// - acknowledge plus strobe moves one byte
// - enable clear halts after current byte
// - automatic mode splits block into packets
// - automatic mode requests and re-arms by itself
// - automatic stops on last packet or zero
// - lower select picks multiplexed or plain bus
module efd_dma_core
    import efd_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register port
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // host bus pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic dma_acknowledge_n,
    input wire logic addr_select_or_latch,
    input wire logic interface_select_hi,
    input wire logic interface_select_lo,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic dma_request_out,
    // endpoint fifo side
    output logic [2:0] fifo_sel,
    input wire logic [6:0] fifo_level,
    input wire logic fifo_pkt_done,
    input wire logic rx_last_pkt,
    input wire logic [7:0] fifo_rd_data,
    output logic fifo_rd,
    output logic fifo_wr,
    output logic [7:0] fifo_wr_data,
    output logic tx_rearm,
    output logic rx_rearm
);
    efd_regs_if rif();

    efd_axil_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .rif(rif.regs)
    );

    // pin synchroniser; the address pin is never sampled, see fifo_sel
    logic [13:0] sync_a, sync_b;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a <= EFD_SYNC_RST;
            sync_b <= EFD_SYNC_RST;
        end
        else
        begin
            sync_a <= {cs_n, rd_n, wr_n, dma_acknowledge_n, interface_select_hi,
                       interface_select_lo, host_data_bus_in};
            sync_b <= sync_a;
        end
    end

    logic cs_n_s, rd_n_s, wr_n_s, dma_acknowledge_n_n_s, sel_hi_s, sel_lo_s;
    logic [7:0] data_s;
    assign {cs_n_s, rd_n_s, wr_n_s, dma_acknowledge_n_n_s, sel_hi_s, sel_lo_s, data_s} = sync_b;

    efd_state_e state, next_state;
    logic [2:0] ep, next_ep;
    logic [6:0] remaining, next_remaining;
    logic [6:0] byte_cnt, next_byte_cnt;
    logic [8:0] pkt_left, next_pkt_left;
    logic auto_armed, next_auto_armed;
    logic pkt_seen, next_pkt_seen;
    logic req, next_req;
    logic [7:0] dout, next_dout;
    logic oe, next_oe;
    logic rd_p, next_rd_p, wr_p, next_wr_p;
    logic [7:0] wdat, next_wdat;
    logic txr, next_txr, rxr, next_rxr;
    logic done_p, next_done_p;
    logic mode_ok, ep_ok, is_tx, active, strobe, cycle_on, warn_hit, auto_run, trigger;
    logic [6:0] avail, qty;

    always_comb
    begin
        mode_ok = !sel_hi_s;
        ep_ok = (ep >= EFD_EP_FIRST) && (ep <= EFD_EP_LAST);
        is_tx = ep[0];
        active = rif.dma_en && mode_ok && ep_ok;
        strobe = is_tx ? !wr_n_s : !rd_n_s;
        cycle_on = !dma_acknowledge_n_n_s && cs_n_s && strobe;
        avail = is_tx ? 7'(EFD_FIFO_DEPTH - fifo_level) : fifo_level;
        warn_hit = rif.warn_en && (avail >= rif.warn_lvl);
        auto_run = rif.auto_mode && auto_armed;
        if (auto_run)
            trigger = (avail >= EFD_FIFO_DEPTH) && (pkt_left != 9'h000);
        else if (rif.timing_sel)
            trigger = avail != 7'h00;
        else
            trigger = warn_hit || (pkt_seen && avail != 7'h00);
        qty = auto_run ? EFD_FIFO_DEPTH : avail;
    end

    always_comb
    begin
        next_state = state;
        next_ep = ep;
        next_remaining = remaining;
        next_byte_cnt = byte_cnt;
        next_pkt_left = pkt_left;
        next_auto_armed = auto_armed;
        // a packet end in the consuming cycle is kept, not lost
        next_pkt_seen = pkt_seen || fifo_pkt_done;
        next_dout = dout;
        next_oe = 1'b0;
        next_rd_p = 1'b0;
        next_wr_p = 1'b0;
        next_wdat = wdat;
        next_txr = 1'b0;
        next_rxr = 1'b0;
        next_done_p = 1'b0;
        // arm only while DMA is still disabled
        if (rif.auto_mode && !rif.dma_en)
            next_auto_armed = 1'b1;
        else if (!rif.auto_mode)
            next_auto_armed = 1'b0;
        if (rif.pkt_load)
            next_pkt_left = rif.pkt_value;
        case (state)
            EFD_IDLE:
            begin
                // FIFO address from the source field
                next_ep = rif.src_ep;
                if (active && trigger)
                begin
                    next_state = EFD_REQ;
                    next_remaining = qty;
                    next_byte_cnt = 7'h00;
                    next_pkt_seen = fifo_pkt_done;
                end
            end
            EFD_REQ:
            begin
                if (!active || remaining == 7'h00 || avail == 7'h00)
                    next_state = EFD_DONE;
                else if (cycle_on)
                begin
                    next_state = EFD_XFER;
                    next_dout = fifo_rd_data;
                    next_oe = !is_tx;
                end
            end
            EFD_XFER:
            begin
                next_oe = !is_tx;
                if (!cycle_on)
                begin
                    next_oe = 1'b0;
                    next_rd_p = !is_tx;
                    next_wr_p = is_tx;
                    next_remaining = 7'(remaining - 7'h01);
                    next_byte_cnt = 7'(byte_cnt + 7'h01);
                    if (remaining == 7'h01 || !active)
                        next_state = EFD_DONE;
                    else
                        next_state = EFD_REQ;
                end
                // released bus may already carry garbage; keep the strobe-low byte
                else
                    next_wdat = data_s;
            end
            EFD_DONE:
            begin
                next_state = EFD_IDLE;
                next_done_p = 1'b1;
                if (auto_run && remaining == 7'h00)
                begin
                    next_txr = is_tx;
                    next_rxr = !is_tx;
                    next_pkt_left = 9'(pkt_left - 9'h001);
                    // stop on count or last packet
                    if (pkt_left == 9'h001 || (!is_tx && rx_last_pkt))
                        next_auto_armed = 1'b0;
                end
            end
            default:
                next_state = EFD_IDLE;
        endcase
        // request stays up through a byte so the partner can finish it
        next_req = (next_state == EFD_REQ) || (next_state == EFD_XFER);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= EFD_IDLE;
            ep <= 3'h0;
            remaining <= 7'h00;
            byte_cnt <= 7'h00;
            pkt_left <= EFD_PKT_RST;
            auto_armed <= 1'b0;
            pkt_seen <= 1'b0;
            req <= 1'b0;
            dout <= 8'h00;
            oe <= 1'b0;
            rd_p <= 1'b0;
            wr_p <= 1'b0;
            wdat <= 8'h00;
            txr <= 1'b0;
            rxr <= 1'b0;
            done_p <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ep <= next_ep;
            remaining <= next_remaining;
            byte_cnt <= next_byte_cnt;
            pkt_left <= next_pkt_left;
            auto_armed <= next_auto_armed;
            pkt_seen <= next_pkt_seen;
            req <= next_req;
            dout <= next_dout;
            oe <= next_oe;
            rd_p <= next_rd_p;
            wr_p <= next_wr_p;
            wdat <= next_wdat;
            txr <= next_txr;
            rxr <= next_rxr;
            done_p <= next_done_p;
        end
    end

    assign dma_request_out = req;
    assign host_data_bus_out = dout;
    assign host_data_bus_oe = oe;
    assign fifo_sel = ep;
    assign fifo_rd = rd_p;
    assign fifo_wr = wr_p;
    assign fifo_wr_data = wdat;
    assign tx_rearm = txr;
    assign rx_rearm = rxr;
    assign rif.req = req;
    assign rif.busy = state != EFD_IDLE;
    assign rif.auto_active = auto_run;
    assign rif.mode_ok = mode_ok;
    assign rif.multiplexed = mode_ok && sel_lo_s;
    assign rif.done_set = done_p;
    assign rif.byte_cnt = byte_cnt;
    assign rif.pkt_left = pkt_left;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_serial_blocks;
        (state == EFD_IDLE && !mode_ok) |=> !dma_request_out;
    endproperty
    a_serial_blocks: assert property (p_serial_blocks)
        else $error("request raised in serial mode");

    property p_ep_range;
        dma_request_out |-> (fifo_sel >= 3'h1 && fifo_sel <= 3'h6);
    endproperty
    a_ep_range: assert property (p_ep_range)
        else $error("request for endpoint outside range");

    property p_cs_priority;
        (state == EFD_REQ && !cs_n_s && active && avail != 7'h00 && remaining != 7'h00)
            |=> state == EFD_REQ;
    endproperty
    a_cs_priority: assert property (p_cs_priority)
        else $error("acknowledge taken while chip select active");

    property p_byte_moves;
        (state == EFD_XFER && !cycle_on) |=> (fifo_rd ^ fifo_wr) ##1 !(fifo_rd || fifo_wr);
    endproperty
    a_byte_moves: assert property (p_byte_moves)
        else $error("completed byte did not move exactly once");

    property p_immediate;
        (state == EFD_IDLE && active && rif.timing_sel && !auto_run && avail != 7'h00)
            |=> dma_request_out;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("immediate request not raised");

    property p_finish_byte;
        (state == EFD_XFER && cycle_on) |=> dma_request_out;
    endproperty
    a_finish_byte: assert property (p_finish_byte)
        else $error("request dropped inside a byte cycle");

    property p_drop_done;
        (state == EFD_DONE) |-> !dma_request_out ##1 !dma_request_out;
    endproperty
    a_drop_done: assert property (p_drop_done)
        else $error("request held after block end");

    property p_auto_rearm;
        (state == EFD_DONE && auto_run && remaining == 7'h00) |=> (tx_rearm || rx_rearm);
    endproperty
    a_auto_rearm: assert property (p_auto_rearm)
        else $error("automatic packet not re-armed");

    property p_auto_stop;
        (state == EFD_DONE && auto_run && remaining == 7'h00 && pkt_left == 9'h001
            && !rif.pkt_load) |=> (!auto_armed && pkt_left == 9'h000);
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("automatic mode did not stop at zero");

    c_std_block: cover property (state == EFD_DONE && !auto_run && byte_cnt > 7'h01);
    c_auto_pkt: cover property (tx_rearm || rx_rearm);
    c_halt: cover property (state == EFD_XFER && !rif.dma_en);
    c_cs_override: cover property (state == EFD_REQ && !cs_n_s && !dma_acknowledge_n_n_s);
endmodule

// *** bench/efd_flyby_model.sv ***
`timescale 1ns/1ps
module efd_flyby_model (
    // clock, request and endpoint
    input wire logic aclk,
    input wire logic dma_request_out,
    input wire logic [2:0] fifo_sel,
    // strobes and data toward the device
    output logic dma_acknowledge_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] host_data_bus_in
);
    initial
    begin
        {dma_acknowledge_n, rd_n, wr_n, host_data_bus_in} = 11'h7ff;
        forever
        begin
            @(posedge aclk);
            if (dma_request_out)
            begin
                dma_acknowledge_n <= 1'b0;
                rd_n <= fifo_sel[0];
                wr_n <= !fifo_sel[0];
                host_data_bus_in <= 8'($urandom);
                repeat (4) @(posedge aclk);
                {dma_acknowledge_n, rd_n, wr_n} <= 3'h7;
                // released bus must not keep the byte
                host_data_bus_in <= ~host_data_bus_in;
                repeat (3 + $urandom % 4) @(posedge aclk);
            end
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import efd_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, cs_n = 1'b1, addr_select_or_latch = 1'b0;
    logic interface_select_hi = 1'b0, interface_select_lo = 1'b0;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, fifo_pkt_done = 1'b0, rx_last_pkt = 1'b0;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00, fifo_rd_data = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'hf;
    logic [6:0] fifo_level = 7'h00;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [7:0] host_data_bus_in, host_data_bus_out, fifo_wr_data;
    logic [2:0] fifo_sel;
    logic host_data_bus_oe, dma_request_out, dma_acknowledge_n, rd_n, wr_n;
    logic fifo_rd, fifo_wr, tx_rearm, rx_rearm;
    logic [7:0] dbyte, wbyte;
    logic [33:0] exp_q[$], msk_q[$], e, m;
    int failures = 0, n_compared = 0, cyc = 0, rearms = 0, n;

    efd_dma_core uut (.*);
    efd_flyby_model far_end (.*);

    initial
    begin
        forever #4 aclk = ~aclk;
    end

    task conclude;
        $display("mismatches %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want)
        begin
            failures++;
            $display("CHECK FAILED %0t pin value", $time);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axil_awaddr, s_axil_wdata} <= {a, d};
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (!s_axil_bvalid);
        s_axil_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [33:0] ev, input logic [33:0] mv);
        @(posedge aclk);
        exp_q.push_back(ev);
        msk_q.push_back(mv);
        {s_axil_araddr, s_axil_arvalid, s_axil_rready} <= {a, 2'h3};
        do @(negedge aclk); while (!s_axil_arready);
        @(posedge aclk);
        s_axil_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axil_rvalid);
        @(posedge aclk);
        s_axil_rready <= 1'b0;
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        fifo_rd_data <= 8'($urandom);
        addr_select_or_latch <= 1'($urandom);
        // behavioural endpoint fifo
        if (fifo_rd) fifo_level <= fifo_level - 7'h01;
        else if (fifo_wr) fifo_level <= fifo_level + 7'h01;
        else if (rx_rearm) fifo_level <= EFD_FIFO_DEPTH;
        if (rx_rearm || tx_rearm) rearms <= rearms + (tx_rearm ? 16 : 1);
        if (!host_data_bus_oe) dbyte <= fifo_rd_data;
        else chk(32'(host_data_bus_out), 32'(dbyte));
        if (!dma_acknowledge_n && !wr_n) wbyte <= host_data_bus_in;
        if (fifo_wr) chk(32'(fifo_wr_data), 32'(wbyte));
        if (s_axil_rvalid && s_axil_rready)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            n_compared++;
            if (({s_axil_rresp, s_axil_rdata} & m) !== e)
            begin
                failures++;
                $display("CHECK FAILED %0t register read", $time);
            end
        end
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        void'($urandom(4998));
        interface_select_lo <= 1'($urandom);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(EFD_OFF_CTRL, 34'h0, '1);
        rd(EFD_OFF_WARN, 34'h20, '1);
        rd(8'h10, {EFD_RESP_SLVERR, 32'h0}, '1);
        interface_select_hi <= 1'b1;
        fifo_level <= 7'h05;
        wr(EFD_OFF_CTRL, 32'h15);
        repeat (20) @(posedge aclk);
        rd(EFD_OFF_STAT, 34'h0, 34'h11);
        wr(EFD_OFF_CTRL, 32'h0);
        interface_select_hi <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            n = 1 + $urandom % 40;
            fifo_level <= 7'((i == 0) ? n : 64 - n);
            if (i == 1) wr(EFD_OFF_WARN, 32'(n));
            wr(EFD_OFF_CTRL, (i == 0) ? 32'h05 : 32'h43);
            fifo_pkt_done <= (i == 0);
            @(posedge aclk);
            fifo_pkt_done <= 1'b0;
            repeat (8) @(posedge aclk);
            while (dma_request_out) @(posedge aclk);
            repeat (4) @(posedge aclk);
            chk(32'(fifo_level), (i == 0) ? 32'h0 : 32'h40);
            rd(EFD_OFF_STAT, 34'(32'h18 | (n << 8) | (32'(interface_select_lo) << 5)),
               34'h3_0000_7f3b);
            wr(EFD_OFF_STAT, 32'h8);
            rd(EFD_OFF_STAT, 34'h0, 34'h8);
            wr(EFD_OFF_CTRL, 32'h0);
        end
        fifo_level <= 7'h30;
        wr(EFD_OFF_CTRL, 32'h15);
        repeat (30) @(posedge aclk);
        cs_n <= 1'b0;
        repeat (16) @(posedge aclk);
        n = int'(fifo_level);
        repeat (40) @(posedge aclk);
        chk(32'(fifo_level), 32'(n));
        cs_n <= 1'b1;
        wr(EFD_OFF_CTRL, 32'h0);
        repeat (14) @(posedge aclk);
        chk({dma_request_out, host_data_bus_oe}, 32'h0);
        fifo_level <= EFD_FIFO_DEPTH;
        for (int j = 0; j < 2; j++)
        begin
            rx_last_pkt <= (j == 1);
            wr(EFD_OFF_PKT, 32'h2 + j);
            wr(EFD_OFF_CTRL, 32'h24);
            wr(EFD_OFF_CTRL, 32'h25);
            while (rearms < 2 + j) @(posedge aclk);
            repeat (10) @(posedge aclk);
            chk(32'(rearms), 32'h2 + j);
            rd(EFD_OFF_STAT, 34'(j << 17), 34'h1ff_0001);
        end
        conclude();
    end
endmodule
